// ---- shared/phy_event_pkg.sv ----
// Summary of operation
// - Each event sets its status bit; reading the status register clears all pending bits.
// - An event with its per-event enable set raises an interrupt request.
// - Interrupts reach the pin only while control bits 1 and 0 are both set.
// - Status bits update whatever the per-event or global enables say.
// - Event status register bits 15 and 7 ignore writes and read zero.
// - Pending flags sit at bits 14 down to 8 in event struct order.
// - Enables 6 down to 0 gate events eight bits higher; reset to zero.
// - False-carrier count in bits 7:0 counts events; bits 15:8 read zero.
// - False-carrier count passing the half-full value raises its half-full event.
// - Reading either counter returns the count and then clears it.
// - Receive-error counter counts errors only with carrier, data valid and invalid symbol.
// - Receive-error counting is suppressed in loopback mode.
// - Receive-error counter saturates at its maximum without wrapping.
// - Receive-error count passing the half-full value raises its half-full event.
// - Half-full events sit in the first status register at 9 and 8, enables 1 and 0.
// - Output-select bit set makes the shared pin an active-low interrupt, else power-down input.
package phy_event_pkg;
	// Register addresses
	localparam logic [4:0]  ADDR_PHY_CTRL      = 5'h11;
	localparam logic [4:0]  ADDR_STATUS_ONE    = 5'h12;
	localparam logic [4:0]  ADDR_STATUS_TWO    = 5'h13;
	localparam logic [4:0]  ADDR_FALSE_CARRIER = 5'h14;
	localparam logic [4:0]  ADDR_RX_ERROR      = 5'h15;
	// Control register fields
	localparam int          CTRL_INT_OE        = 0;
	localparam int          CTRL_INT_EN        = 1;
	localparam int          CTRL_TEST_INT      = 2;
	localparam logic [2:0]  CTRL_RESET         = 3'h0;
	// Status/enable layout: flags sit this many bits above their enables
	localparam int          EVT_SHIFT          = 8;
	localparam int          ST2_EVT_LSB        = 8;
	localparam int          ST2_EVT_MSB        = 14;
	localparam int          ST1_EVT_LSB        = 8;
	localparam int          ST1_EVT_MSB        = 9;
	localparam logic [6:0]  ST2_RESET          = 7'h00;
	localparam logic [1:0]  ST1_RESET          = 2'h0;
	// Counter limits
	localparam logic [7:0]  FC_MAX             = 8'hff;
	localparam logic [7:0]  FC_HALF            = 8'h7f;
	localparam logic [15:0] RE_MAX             = 16'hffff;
	localparam logic [15:0] RE_HALF            = 16'h7fff;

	// Register port request
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} regReq_t;

	// PHY events, most significant first to match status bits 14..8
	typedef struct packed {
		logic anError;
		logic pageReceived;
		logic loopFifoError;
		logic crossoverChange;
		logic sleepEvent;
		logic polarityChange;
		logic jabber;
	} phyEvents_t;
endpackage : phy_event_pkg

// ---- hw/phy_event_status.sv ----
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module phy_event_status (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// Register port
	input  wire phy_event_pkg::regReq_t    regReq,
	output logic [15:0]                    rdData,
	// PHY events, one-cycle pulses
	input  wire phy_event_pkg::phyEvents_t phyEvents,
	input  wire logic                      falseCarrier,
	input  wire logic                      rxError,
	input  wire logic                      carrierValid,
	input  wire logic                      rxDataValid,
	input  wire logic                      invalidSymbol,
	input  wire logic                      miiLoopback,
	// Shared interrupt / power-down pin
	input  wire logic                      irqPinIn,
	output logic                           irqPinOut_n,
	output logic                           irqPinOe,
	// Status to the rest of the PHY
	output logic                           powerDownReq,
	output logic                           intPending
);
	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [2:0]  ctrl_reg;
	logic [2:0]  ctrl_next;
	logic [6:0]  st2_reg;
	logic [6:0]  st2_next;
	logic [6:0]  en2_reg;
	logic [6:0]  en2_next;
	logic [1:0]  st1_reg;
	logic [1:0]  st1_next;
	logic [1:0]  en1_reg;
	logic [1:0]  en1_next;
	logic [7:0]  fc_reg;
	logic [7:0]  fc_next;
	logic [15:0] re_reg;
	logic [15:0] re_next;
	logic [15:0] rdData_reg;
	logic [15:0] rdData_next;
	logic        int_next;
	logic        irqOut_reg;
	logic        irqOe_reg;
	logic        intPend_reg;
	logic        pdSync1_reg;
	logic        pdSync2_reg;
	logic        powerDown_reg;

	// Decoded accesses
	logic wrCtrl;
	logic wrSt1;
	logic wrSt2;
	logic rdSt1;
	logic rdSt2;
	logic rdFc;
	logic rdRe;
	logic reCount;
	logic fcHalfEvt;
	logic reHalfEvt;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	assign wrCtrl = regReq.wr && (regReq.addr == phy_event_pkg::ADDR_PHY_CTRL);
	assign wrSt1  = regReq.wr && (regReq.addr == phy_event_pkg::ADDR_STATUS_ONE);
	assign wrSt2  = regReq.wr && (regReq.addr == phy_event_pkg::ADDR_STATUS_TWO);
	assign rdSt1  = regReq.rd && (regReq.addr == phy_event_pkg::ADDR_STATUS_ONE);
	assign rdSt2  = regReq.rd && (regReq.addr == phy_event_pkg::ADDR_STATUS_TWO);
	assign rdFc   = regReq.rd && (regReq.addr == phy_event_pkg::ADDR_FALSE_CARRIER);
	assign rdRe   = regReq.rd && (regReq.addr == phy_event_pkg::ADDR_RX_ERROR);

	////////////////////////////////////////////////////////////////////////////////
	// Control and enable registers: software writes steer pin mode and gating
	always_comb begin
		ctrl_next = wrCtrl ? regReq.wdata[2:0] : ctrl_reg;
		en2_next  = wrSt2 ? regReq.wdata[6:0] : en2_reg;
		en1_next  = wrSt1 ? regReq.wdata[1:0] : en1_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= phy_event_pkg::CTRL_RESET;
			en2_reg  <= phy_event_pkg::ST2_RESET;
			en1_reg  <= phy_event_pkg::ST1_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
			en2_reg  <= en2_next;
			en1_reg  <= en1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// False-carrier counter: saturates, cleared on read, increment on read kept
	always_comb begin
		if (rdFc) begin
			fc_next = {7'h00, falseCarrier};
		end else if (falseCarrier && fc_reg != phy_event_pkg::FC_MAX) begin
			fc_next = 8'(fc_reg + 8'h01);
		end else begin
			fc_next = fc_reg;
		end
	end

	// Half-full event on the step past the half value
	assign fcHalfEvt = falseCarrier && !rdFc && (fc_reg == phy_event_pkg::FC_HALF);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fc_reg <= 8'h00;
		end else begin
			fc_reg <= fc_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive-error counter: qualified, idle in loopback, saturates
	assign reCount = rxError && carrierValid && rxDataValid && invalidSymbol
	                 && !miiLoopback;

	always_comb begin
		if (rdRe) begin
			re_next = {15'h0000, reCount};
		end else if (reCount && re_reg != phy_event_pkg::RE_MAX) begin
			re_next = 16'(re_reg + 16'h0001);
		end else begin
			re_next = re_reg;
		end
	end

	assign reHalfEvt = reCount && !rdRe && (re_reg == phy_event_pkg::RE_HALF);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			re_reg <= 16'h0000;
		end else begin
			re_reg <= re_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky event flags: set regardless of enables, cleared by a read, set beats clear
	// The clear masks only old flags, so an event in the read cycle is kept for the next read
	always_comb begin
		st2_next = (st2_reg & ~{7{rdSt2}}) | phyEvents;
		st1_next = (st1_reg & ~{2{rdSt1}}) | {fcHalfEvt, reHalfEvt};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st2_reg <= phy_event_pkg::ST2_RESET;
			st1_reg <= phy_event_pkg::ST1_RESET;
		end else begin
			st2_reg <= st2_next;
			st1_reg <= st1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; zero otherwise and for unmapped addresses
	always_comb begin
		rdData_next = 16'h0000;
		if (regReq.rd) begin
			unique case (regReq.addr)
				phy_event_pkg::ADDR_PHY_CTRL: begin
					rdData_next = {13'h0000, ctrl_reg};
				end
				phy_event_pkg::ADDR_STATUS_ONE: begin
					rdData_next = {6'h00, st1_reg, 6'h00, en1_reg};
				end
				phy_event_pkg::ADDR_STATUS_TWO: begin
					rdData_next = {1'b0, st2_reg, 1'b0, en2_reg};
				end
				phy_event_pkg::ADDR_FALSE_CARRIER: begin
					rdData_next = {8'h00, fc_reg};
				end
				phy_event_pkg::ADDR_RX_ERROR: begin
					rdData_next = re_reg;
				end
				default: begin
					rdData_next = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 16'h0000;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt: enabled pending flags, or the test bit, gated by both global bits
	// Next-state terms let the pin move at the same edge as the flag it reports
	assign int_next = ctrl_next[phy_event_pkg::CTRL_INT_EN]
	                  && ctrl_next[phy_event_pkg::CTRL_INT_OE]
	                  && ((|(st2_next & en2_next))
	                      || (|(st1_next & en1_next))
	                      || ctrl_next[phy_event_pkg::CTRL_TEST_INT]);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			intPend_reg <= 1'b0;
			irqOut_reg  <= 1'b1;
			irqOe_reg   <= 1'b0;
		end else begin
			intPend_reg <= int_next;
			irqOut_reg  <= ~int_next;
			irqOe_reg   <= ctrl_next[phy_event_pkg::CTRL_INT_OE];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-down input: pin synchronised, honoured only while the pin is an input
	// The pin idles high, so the flops reset high to avoid a false request after reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pdSync1_reg   <= 1'b1;
			pdSync2_reg   <= 1'b1;
			powerDown_reg <= 1'b0;
		end else begin
			pdSync1_reg   <= irqPinIn;
			pdSync2_reg   <= pdSync1_reg;
			powerDown_reg <= !ctrl_reg[phy_event_pkg::CTRL_INT_OE] && !pdSync2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdData       = rdData_reg;
	assign irqPinOut_n  = irqOut_reg;
	assign irqPinOe     = irqOe_reg;
	assign powerDownReq = powerDown_reg;
	assign intPending   = intPend_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Flags stay set until a read of their register
	a_status_sticky: assert property (!rdSt2 |=> ((st2_reg & $past(st2_reg)) == $past(st2_reg)))
		else $error("status flag lost without read");

	// A read with no new event leaves the flags empty
	a_read_clears: assert property (rdSt2 && phyEvents == 7'h00 |=> st2_reg == 7'h00)
		else $error("status read did not clear flags");

	// Enabled event raises the interrupt next cycle when globals are on
	a_event_raises: assert property ((|(phyEvents & en2_reg)) && ctrl_reg[1:0] == 2'b11 && !wrCtrl && !wrSt2
		|=> intPending && !irqPinOut_n)
		else $error("enabled event did not interrupt");

	// No interrupt without both global bits
	a_global_gate: assert property (intPending |-> ctrl_reg[1] && ctrl_reg[0])
		else $error("interrupt without global enables");

	// Flag set even with everything disabled
	a_flag_no_enable: assert property (phyEvents.jabber && en2_reg[0] == 1'b0 |=> st2_reg[0])
		else $error("flag not set while disabled");

	// Reserved bits read zero
	a_reserved_zero: assert property (rdSt2 |=> rdData[15] == 1'b0 && rdData[7] == 1'b0)
		else $error("reserved bits not zero");

	// Flag position and enable position line up on read
	a_read_layout: assert property (rdSt2 |=> rdData[14:8] == $past(st2_reg) && rdData[6:0] == $past(en2_reg))
		else $error("status layout wrong");

	// Enable write reads back on the next read
	a_enable_store: assert property (wrSt2 ##1 rdSt2 |=> rdData[6:0] == $past(regReq.wdata[6:0], 2))
		else $error("enable not stored");

	// Upper false-carrier bits read zero
	a_fc_upper: assert property (rdFc |=> rdData[15:8] == 8'h00 && rdData[7:0] == $past(fc_reg))
		else $error("false carrier read wrong");

	// False-carrier counter saturates
	a_fc_saturate: assert property (fc_reg == 8'hff && !rdFc |=> fc_reg == 8'hff)
		else $error("false carrier counter wrapped");

	// Half-full crossing flags the event
	a_fc_half: assert property (fc_reg == 8'h7f && falseCarrier && !rdFc |=> fc_reg == 8'h80 && st1_reg[1])
		else $error("false carrier half-full missed");

	// Read returns count then clears, same-cycle count kept
	a_re_clear: assert property (rdRe |=> rdData == $past(re_reg) && re_reg == {15'h0000, $past(reCount)})
		else $error("receive error clear-on-read wrong");

	// Qualified error counts by one
	a_re_count: assert property (reCount && !rdRe && re_reg != 16'hffff |=> re_reg == 16'($past(re_reg) + 16'h0001))
		else $error("receive error not counted");

	// Loopback freezes the counter
	a_loop_quiet: assert property (miiLoopback && !rdRe |=> re_reg == $past(re_reg))
		else $error("counted in loopback");

	// Receive-error counter saturates
	a_re_saturate: assert property (re_reg == 16'hffff && !rdRe |=> re_reg == 16'hffff)
		else $error("receive error counter wrapped");

	// Receive-error half-full crossing flags the event
	a_re_half: assert property (reHalfEvt |=> st1_reg[0] && re_reg == 16'h8000)
		else $error("receive error half-full missed");

	// Half-full flag survives until read
	a_half_sticky: assert property (st1_reg[1] && !rdSt1 |=> st1_reg[1])
		else $error("half-full flag lost");

	// Pin direction follows the output-select write
	a_pin_mode: assert property (wrCtrl |=> irqPinOe == $past(regReq.wdata[0]))
		else $error("pin mode not applied");

	// Event arriving with the clearing read is kept
	a_keep_on_read: assert property (rdSt2 && phyEvents != 7'h00 |=> (st2_reg & $past(phyEvents)) == $past(phyEvents))
		else $error("event lost on read");

	// Pin released once nothing enabled is pending and no test force
	a_irq_release: assert property ((st2_reg & en2_reg) == 7'h00 && (st1_reg & en1_reg) == 2'h0
		&& !ctrl_reg[phy_event_pkg::CTRL_TEST_INT] |-> !intPending && irqPinOut_n)
		else $error("pin asserted without pending interrupt");

	// Test force interrupts when both global bits are set
	a_test_force: assert property (ctrl_reg == 3'h7 && !wrCtrl |=> intPending && !irqPinOut_n)
		else $error("test force did not interrupt");

	// False-carrier event counts by one below the maximum
	a_fc_count: assert property (falseCarrier && !rdFc && fc_reg != phy_event_pkg::FC_MAX |=> fc_reg == 8'($past(fc_reg) + 8'h01))
		else $error("false carrier not counted");

	// False-carrier count holds with no event and no read
	a_fc_idle: assert property (!falseCarrier && !rdFc |=> fc_reg == $past(fc_reg))
		else $error("false carrier count moved");

	// False-carrier read clears, same-cycle event kept
	a_fc_clear: assert property (rdFc |=> fc_reg == {7'h00, $past(falseCarrier)})
		else $error("false carrier clear-on-read wrong");

	// Receive-error count holds with no qualified error and no read
	a_re_idle: assert property (!reCount && !rdRe |=> re_reg == $past(re_reg))
		else $error("receive error count moved");

	// Loopback never raises the receive-error half-full event
	a_loop_no_half: assert property (miiLoopback |-> !reHalfEvt)
		else $error("half-full event in loopback");

	// First status register layout on read
	a_st1_layout: assert property (rdSt1 |=> rdData == {6'h00, $past(st1_reg), 6'h00, $past(en1_reg)})
		else $error("status one layout wrong");

	// Enabled half-full event raises the interrupt when globals are on
	a_half_raises: assert property ((|({fcHalfEvt, reHalfEvt} & en1_reg)) && ctrl_reg[1:0] == 2'b11 && !wrCtrl && !wrSt1
		|=> intPending && !irqPinOut_n)
		else $error("half-full event did not interrupt");

	// Power-down request only while the pin was an input
	a_pd_gate: assert property (powerDownReq |-> !$past(ctrl_reg[phy_event_pkg::CTRL_INT_OE]))
		else $error("power-down while pin is an output");

	// Writes never change the event flags
	a_flags_ro: assert property (wrSt2 && phyEvents == 7'h00 |=> st2_reg == $past(st2_reg))
		else $error("write changed status flags");

	// Read data stands one cycle only
	a_rd_idle: assert property (!regReq.rd |=> rdData == 16'h0000)
		else $error("read data without read");

	// Enables hold without a write
	a_en_hold: assert property (!wrSt2 |=> en2_reg == $past(en2_reg))
		else $error("enable changed without write");
endmodule : phy_event_status

// ---- testbench/tb_phy_event_status_and_error_counters.sv ----
`timescale 1ns/100ps
module tb_phy_event_status_and_error_counters;
	logic                       ref_clk;
	logic                       rst_n;
	phy_event_pkg::regReq_t     regReq;
	logic [15:0]                rdData;
	phy_event_pkg::phyEvents_t  phyEvents;
	logic                       falseCarrier;
	logic                       rxError;
	logic                       carrierValid;
	logic                       rxDataValid;
	logic                       invalidSymbol;
	logic                       miiLoopback;
	logic                       irqPinIn;
	logic                       irqPinOut_n;
	logic                       irqPinOe;
	logic                       powerDownReq;
	logic                       intPending;
	int                         err_count;
	int                         n_tests;
	int                         i;

	////////////////////////////////////////////////////////////////////////////////
	// Device under test
	phy_event_status dut (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.regReq        (regReq),
		.rdData        (rdData),
		.phyEvents     (phyEvents),
		.falseCarrier  (falseCarrier),
		.rxError       (rxError),
		.carrierValid  (carrierValid),
		.rxDataValid   (rxDataValid),
		.invalidSymbol (invalidSymbol),
		.miiLoopback   (miiLoopback),
		.irqPinIn      (irqPinIn),
		.irqPinOut_n   (irqPinOut_n),
		.irqPinOe      (irqPinOe),
		.powerDownReq  (powerDownReq),
		.intPending    (intPending)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk

	// One-cycle register write
	task regWrite(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regReq.addr  <= a;
		regReq.wdata <= d;
		regReq.wr    <= 1'b1;
		@(posedge ref_clk);
		regReq.wr    <= 1'b0;
		#1;
	endtask : regWrite

	// One-cycle register read, data checked in the following cycle
	task regCheck(input logic [4:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		regReq.addr <= a;
		regReq.rd   <= 1'b1;
		@(posedge ref_clk);
		regReq.rd   <= 1'b0;
		#1;
		chk(rdData, exp);
	endtask : regCheck

	// Interrupt level and active-low pin value together
	task pinCheck(input logic expInt);
		chk({14'h0, intPending, irqPinOut_n}, {14'h0, expInt, ~expInt});
	endtask : pinCheck

	// One-cycle pulse on the selected event inputs
	task evPulse(input logic [6:0] bits);
		@(posedge ref_clk);
		phyEvents <= bits;
		@(posedge ref_clk);
		phyEvents <= '0;
		#1;
	endtask : evPulse

	// Hold a counter input high for n sampled edges: 0 false carrier, 1 receive error
	task burst(input int which, input int n);
		@(posedge ref_clk);
		if (which == 0) begin
			falseCarrier <= 1'b1;
		end else begin
			rxError <= 1'b1;
		end
		repeat (n) @(posedge ref_clk);
		falseCarrier <= 1'b0;
		rxError      <= 1'b0;
	endtask : burst

	// Verdict and end of run
	task complete_run;
		$display("Checks %0d, errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the sequence needs about 70600 cycles
	initial begin
		repeat (90000) @(posedge ref_clk);
		err_count++;
		complete_run;
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		regReq = '0;
		phyEvents = '0;
		falseCarrier = 1'b0;
		rxError = 1'b0;
		{miiLoopback, carrierValid, rxDataValid, invalidSymbol} = 4'h0;
		irqPinIn = 1'b1;
		err_count = 0;
		n_tests = 0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		// Reset state of pin and registers, unmapped places included
		chk({13'h0, irqPinOe, intPending, irqPinOut_n}, 16'h0001);
		for (i = 16; i < 22; i++) begin
			regCheck(5'(i), 16'h0000);
		end
		regWrite(5'h1f, 16'hffff);
		regCheck(5'h1f, 16'h0000);
		// Enables and reserved bits
		regWrite(phy_event_pkg::ADDR_STATUS_TWO, 16'hffff);
		regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h007f);
		// Write then read back to back, no gap
		@(posedge ref_clk);
		regReq.addr  <= phy_event_pkg::ADDR_STATUS_TWO;
		regReq.wdata <= 16'h0055;
		regReq.wr    <= 1'b1;
		@(posedge ref_clk);
		regReq.wr    <= 1'b0;
		regReq.rd    <= 1'b1;
		@(posedge ref_clk);
		regReq.rd    <= 1'b0;
		#1;
		chk(rdData, 16'h0055);
		regWrite(phy_event_pkg::ADDR_STATUS_TWO, 16'h0000);
		// Flags latch with every enable off
		evPulse(7'h7f);
		pinCheck(1'b0);
		regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h7f00);
		regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h0000);
		// Each event raises the interrupt through its own enable
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0003);
		chk({15'h0, irqPinOe}, 16'h0001);
		for (i = 0; i < 7; i++) begin
			regWrite(phy_event_pkg::ADDR_STATUS_TWO, 16'h0001 << i);
			evPulse(7'h01 << i);
			pinCheck(1'b1);
			regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h0101 << i);
			pinCheck(1'b0);
		end
		// A flag whose enable is off raises nothing
		regWrite(phy_event_pkg::ADDR_STATUS_TWO, 16'h0001);
		evPulse(7'h02);
		pinCheck(1'b0);
		regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h0201);
		// Both global enables gate the pending interrupt
		evPulse(7'h01);
		pinCheck(1'b1);
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0002);
		#1;
		pinCheck(1'b0);
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0001);
		#1;
		pinCheck(1'b0);
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0003);
		#1;
		pinCheck(1'b1);
		regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h0101);
		pinCheck(1'b0);
		// Test force bit, gated by both global bits
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0004);
		pinCheck(1'b0);
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0007);
		pinCheck(1'b1);
		regCheck(phy_event_pkg::ADDR_PHY_CTRL, 16'h0007);
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0003);
		pinCheck(1'b0);
		// Event in the same cycle as the clearing read survives
		@(posedge ref_clk);
		regReq.addr <= phy_event_pkg::ADDR_STATUS_TWO;
		regReq.rd   <= 1'b1;
		phyEvents   <= 7'h01;
		@(posedge ref_clk);
		regReq.rd   <= 1'b0;
		phyEvents   <= '0;
		#1;
		chk(rdData, 16'h0001);
		pinCheck(1'b1);
		regCheck(phy_event_pkg::ADDR_STATUS_TWO, 16'h0101);
		regWrite(phy_event_pkg::ADDR_STATUS_TWO, 16'h0000);
		// False-carrier count, half-full crossing and saturation
		burst(0, 127);
		regCheck(phy_event_pkg::ADDR_STATUS_ONE, 16'h0000);
		burst(0, 1);
		regCheck(phy_event_pkg::ADDR_STATUS_ONE, 16'h0200);
		regCheck(phy_event_pkg::ADDR_FALSE_CARRIER, 16'h0080);
		regCheck(phy_event_pkg::ADDR_FALSE_CARRIER, 16'h0000);
		burst(0, 300);
		regWrite(phy_event_pkg::ADDR_FALSE_CARRIER, 16'hffff);
		regCheck(phy_event_pkg::ADDR_FALSE_CARRIER, 16'h00ff);
		regWrite(phy_event_pkg::ADDR_STATUS_ONE, 16'hffff);
		regCheck(phy_event_pkg::ADDR_STATUS_ONE, 16'h0203);
		// Receive errors count only with all qualifiers and no loopback
		for (i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			{miiLoopback, carrierValid, rxDataValid, invalidSymbol} <= 4'(i);
			burst(1, 1);
		end
		regCheck(phy_event_pkg::ADDR_RX_ERROR, 16'h0001);
		// Receive-error half-full and saturation
		@(posedge ref_clk);
		{miiLoopback, carrierValid, rxDataValid, invalidSymbol} <= 4'h7;
		burst(1, 70000);
		#1;
		pinCheck(1'b1);
		regCheck(phy_event_pkg::ADDR_STATUS_ONE, 16'h0103);
		regCheck(phy_event_pkg::ADDR_RX_ERROR, 16'hffff);
		regCheck(phy_event_pkg::ADDR_RX_ERROR, 16'h0000);
		// Shared pin as power-down input, then back to interrupt output
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0000);
		@(posedge ref_clk);
		irqPinIn <= 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		chk({14'h0, powerDownReq, irqPinOe}, 16'h0002);
		regWrite(phy_event_pkg::ADDR_PHY_CTRL, 16'h0001);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({14'h0, powerDownReq, irqPinOe}, 16'h0001);
		complete_run;
	end
endmodule : tb_phy_event_status_and_error_counters
